/* verilog/qar_dev.sv */
// Four channel receiver chip end of the pin interface
`include "qar_map.svh"
`timescale 1ns/1ps
`default_nettype none
module qar_dev (
   input wire logic i_phi2_clk,
   input wire logic i_rst,
   qar_if.dev pins,
   output logic [3:0] o_status
);
   qar_pkg::qar_dev_t q;
   qar_pkg::qar_dev_t d;
   logic rn, csn, dir, mb, pe, spd;
   logic [1:0] fa;
   logic [3:0] p1, p0;
   logic [7:0] din;

   // -------------------------------------------------
   // Synchronised pin view
   // -------------------------------------------------
   assign {rn, csn, dir, fa, mb, pe, spd, p1, p0, din} = q.s2;

   assign pins.data_d = q.dout;
   assign pins.data_d_oe = q.doe;
   assign pins.irq_d_oe = q.irq_oe;
   assign pins.tx_zero_line_or_chan_bit0 = q.n0;
   assign pins.tx_one_line_or_chan_bit1 = q.n1;
   assign o_status = q.status;

   // -------------------------------------------------
   // Next state
   // -------------------------------------------------
   always_comb begin
      logic act, p_one, p_zero, tx_on;
      logic [1:0] ch;
      logic [7:0] thr;
      logic [6:0] half;
      act = 1'b0;
      p_one = 1'b0;
      p_zero = 1'b0;
      tx_on = 1'b0;
      ch = 2'h0;
      thr = 8'h00;
      half = 7'h00;
      d = q;
      d.s1 = {pins.reset_n, pins.cs_n, pins.dir_or_scan_inhibit,
              pins.func_addr_hi, pins.func_addr_lo, pins.mode_b,
              pins.parity_en, pins.irq_or_speed_sel,
              pins.rx3_one_pulse, pins.rx2_one_pulse,
              pins.rx1_one_pulse, pins.rx0_one_pulse,
              pins.rx3_zero_pulse, pins.rx2_zero_pulse,
              pins.rx1_zero_pulse, pins.rx0_zero_pulse, pins.data_bus};
      d.s2 = q.s1;
      d.op1 = p1;
      d.op0 = p0;

      // Channel in use: scanned, or lowest selected
      if (mb) begin
         ch = q.scan;
      end else begin
         for (int i = 3; i >= 0; i--) begin
            if (q.ctrl[i]) begin
               ch = 2'(i);
            end
         end
      end
      act = ~csn & rn;

      // Access end: last byte read frees the channel
      if (!act && q.act && q.fa_l == `QAR_FA_LAST && (mb || q.dir_l)) begin
         d.status[q.ch_l] = 1'b0;
         d.lock[q.ch_l] = 1'b0;
      end

      // Access start
      if (act && !q.act) begin
         d.dir_l = dir;
         d.fa_l = fa;
         d.ch_l = ch;
         if (!mb && !dir) begin
            case (fa)
               `QAR_FA_CTRL: begin
                  d.ctrl = din;
                  if (din[`QAR_C_TXPROG]) begin
                     d.txidx = 2'h0;
                     d.s4 = 1'b0;
                  end
                  if (din[`QAR_C_START] && !q.ctrl[`QAR_C_START]) begin
                     d.txbits = 6'h00;
                     d.dcnt = 7'h00;
                     d.bclk = 1'b0;
                  end
               end
               `QAR_FA_TXDATA: begin
                  if (q.ctrl[`QAR_C_TXPROG]) begin
                     d.txsr[q.txidx * 8 +: 8] = din;
                     d.txidx = q.txidx + 2'h1;
                  end
               end
               `QAR_FA_DIV: d.div = din & 8'hfe;
               `QAR_FA_LABEL: begin
                  for (int i = 0; i < 4; i++) begin
                     if (q.ctrl[i]) begin
                        d.label[i] = din;
                     end
                  end
               end
               default: d.ctrl = q.ctrl;
            endcase
         end else if (fa != `QAR_FA_CTRL) begin
            d.lock[ch] = 1'b1;
         end
      end
      d.act = act;

      // Receive channels
      for (int i = 0; i < 4; i++) begin
         p_one = p1[i] & ~q.op1[i];
         p_zero = p0[i] & ~q.op0[i];
         if (mb) begin
            thr = (spd && i < 2) ? `QAR_GAP_HI : `QAR_GAP_LO;
         end else begin
            thr = `QAR_GAP_A;
         end
         if (p_one || p_zero) begin
            d.sr[i] = {p_one, q.sr[i][31:1]};
            d.gap[i] = 8'h00;
            if (q.bits[i] != `QAR_BITS_SAT) begin
               d.bits[i] = q.bits[i] + 6'h01;
            end
         end else if (q.gap[i] != thr) begin
            d.gap[i] = q.gap[i] + 8'h01;
         end else if (q.bits[i] != 6'h00) begin
            d.bits[i] = 6'h00;
            if (q.bits[i] == `QAR_WORD_BITS && !d.lock[i]
                && (!pe || ^q.sr[i])
                && (mb || q.sr[i][7:0] == q.label[i])) begin
               d.buff[i] = q.sr[i][31:8];
               if (mb) begin
                  d.label[i] = q.sr[i][7:0];
               end else begin
                  d.status[i] = 1'b1;
               end
            end
         end
      end

      // Transmitter
      half = (q.div[7:1] == 7'h00) ? 7'h01 : q.div[7:1];
      if (q.ctrl[`QAR_C_START] && !mb) begin
         if (q.dcnt + 7'h01 >= half) begin
            d.dcnt = 7'h00;
            d.bclk = ~q.bclk;
            if (q.bclk) begin
               d.txsr = {1'b0, q.txsr[31:1]};
               d.txbits = q.txbits + 6'h01;
               if (q.txbits + 6'h01 == `QAR_TX_END) begin
                  d.ctrl[`QAR_C_START] = 1'b0;
                  d.s4 = 1'b1;
               end
            end
         end else begin
            d.dcnt = q.dcnt + 7'h01;
         end
      end else begin
         d.bclk = 1'b0;
      end

      // Scan counter
      if (mb && !dir) begin
         d.scan = q.scan + 2'h1;
      end

      // Reset pin clears control state
      if (!rn) begin
         d.ctrl = 8'h00;
         d.status = 4'h0;
         d.lock = 4'h0;
         d.s4 = 1'b0;
         d.txidx = 2'h0;
         d.txbits = 6'h00;
         d.bclk = 1'b0;
         d.scan = 2'h0;
      end

      // Pin outputs
      tx_on = d.ctrl[`QAR_C_START] && d.txbits < `QAR_WORD_BITS;
      if (mb) begin
         d.n0 = d.scan[0];
         d.n1 = d.scan[1];
      end else begin
         d.n0 = d.bclk & tx_on & ~d.txsr[0];
         d.n1 = d.bclk & tx_on & d.txsr[0];
      end
      d.doe = act && (mb || dir);
      case (fa)
         2'h0: d.dout = q.buff[ch][7:0];
         2'h1: d.dout = q.buff[ch][15:8];
         2'h2: d.dout = q.buff[ch][23:16];
         default: d.dout = mb ? q.label[ch] :
            {q.ctrl[`QAR_C_START], 2'h0, q.s4, q.status};
      endcase
      d.irq_oe = !mb && (|d.status || (d.s4 && !d.ctrl[`QAR_C_MASK]));
   end

   // -------------------------------------------------
   // State register
   // -------------------------------------------------
   always_ff @(posedge i_phi2_clk) begin
      if (i_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule
`default_nettype wire

/* inc/qar_map.svh */
// Constants for the quad receiver pin interface
`ifndef QAR_MAP_SVH
`define QAR_MAP_SVH
// -------------------------------------------------
// Function addresses
// -------------------------------------------------
`define QAR_FA_TXDATA 2'h0
`define QAR_FA_DIV 2'h1
`define QAR_FA_LABEL 2'h2
`define QAR_FA_CTRL 2'h3
`define QAR_FA_LAST 2'h2
// -------------------------------------------------
// Control bits
// -------------------------------------------------
`define QAR_C_TXPROG 4
`define QAR_C_START 5
`define QAR_C_MASK 7
// -------------------------------------------------
// Timing
// -------------------------------------------------
`define QAR_GAP_A 8'h30
`define QAR_GAP_LO 8'h60
`define QAR_GAP_HI 8'h18
`define QAR_WORD_BITS 6'h20
`define QAR_BITS_SAT 6'h21
`define QAR_TX_END 6'h24
`define QAR_CLK_HZ 50000000
`define QAR_SCAN_MAX_HZ 2000000
`define QAR_SCAN_MIN_CYC ((`QAR_CLK_HZ + `QAR_SCAN_MAX_HZ - 1) / `QAR_SCAN_MAX_HZ)
`define QAR_HOST_DIV 4'h3
`define QAR_HOST_HOLD 8'h3f
`define QAR_HOST_RECOV 8'h1f
`endif

/* inc/qar_pkg.sv */
// Types for the quad receiver pin interface
package qar_pkg;
   typedef enum logic [1:0] {H_IDLE, H_ACCESS, H_RECOV} qar_hstate_t;

   typedef struct packed {
      logic [23:0] s1;
      logic [23:0] s2;
      logic [3:0] op1;
      logic [3:0] op0;
      logic [3:0][31:0] sr;
      logic [3:0][5:0] bits;
      logic [3:0][7:0] gap;
      logic [3:0][7:0] label;
      logic [3:0][23:0] buff;
      logic [3:0] status;
      logic [3:0] lock;
      logic [7:0] ctrl;
      logic [7:0] div;
      logic [6:0] dcnt;
      logic bclk;
      logic [31:0] txsr;
      logic [1:0] txidx;
      logic [5:0] txbits;
      logic s4;
      logic [1:0] scan;
      logic act;
      logic dir_l;
      logic [1:0] fa_l;
      logic [1:0] ch_l;
      logic [7:0] dout;
      logic doe;
      logic irq_oe;
      logic n0;
      logic n1;
   } qar_dev_t;

   typedef struct packed {
      qar_hstate_t st;
      logic [7:0] cnt;
      logic [3:0] div;
      logic phi2;
      logic rst_n;
      logic cs_n;
      logic dir;
      logic [1:0] fa;
      logic [7:0] wdata;
      logic doe;
      logic [7:0] rd1;
      logic [7:0] rd2;
      logic [7:0] rdata;
      logic done;
      logic mode_b;
      logic par_en;
      logic spd;
      logic [3:0] one;
      logic [3:0] zero;
      logic [3:0] misc1;
      logic [3:0] misc2;
   } qar_host_t;
endpackage

/* inc/qar_if.sv */
// Pin bundle joining the receiver chip and its host
`timescale 1ns/1ps
`default_nettype none
interface qar_if;
   logic phi2_clk;
   logic reset_n;
   logic cs_n;
   logic dir_or_scan_inhibit;
   logic func_addr_lo;
   logic func_addr_hi;
   logic mode_b;
   logic parity_en;
   logic [7:0] data_h;
   logic data_h_oe;
   logic [7:0] data_d;
   logic data_d_oe;
   logic [7:0] data_bus;
   logic irq_d_oe;
   logic speed_h;
   logic speed_h_oe;
   logic irq_or_speed_sel;
   logic tx_zero_line_or_chan_bit0;
   logic tx_one_line_or_chan_bit1;
   logic rx0_one_pulse, rx0_zero_pulse;
   logic rx1_one_pulse, rx1_zero_pulse;
   logic rx2_one_pulse, rx2_zero_pulse;
   logic rx3_one_pulse, rx3_zero_pulse;

   // Bus wire with pull-up
   assign data_bus = data_d_oe ? data_d : (data_h_oe ? data_h : 8'hff);
   // Open drain line with pull-up
   assign irq_or_speed_sel = speed_h_oe ? speed_h : ~irq_d_oe;

   modport dev (
      input phi2_clk, reset_n, cs_n, dir_or_scan_inhibit, func_addr_lo,
      input func_addr_hi, mode_b, parity_en, data_bus, irq_or_speed_sel,
      input rx0_one_pulse, rx0_zero_pulse, rx1_one_pulse, rx1_zero_pulse,
      input rx2_one_pulse, rx2_zero_pulse, rx3_one_pulse, rx3_zero_pulse,
      output data_d, data_d_oe, irq_d_oe,
      output tx_zero_line_or_chan_bit0, tx_one_line_or_chan_bit1
   );
   modport host (
      output phi2_clk, reset_n, cs_n, dir_or_scan_inhibit, func_addr_lo,
      output func_addr_hi, mode_b, parity_en, data_h, data_h_oe,
      output speed_h, speed_h_oe,
      output rx0_one_pulse, rx0_zero_pulse, rx1_one_pulse, rx1_zero_pulse,
      output rx2_one_pulse, rx2_zero_pulse, rx3_one_pulse, rx3_zero_pulse,
      input data_bus, irq_or_speed_sel,
      input tx_zero_line_or_chan_bit0, tx_one_line_or_chan_bit1
   );
endinterface
`default_nettype wire

/* verilog/qar_host.sv */
// Host end: bus master, scanner and line pulse driver
`include "qar_map.svh"
`timescale 1ns/1ps
`default_nettype none
module qar_host (
   input wire logic i_clk,
   input wire logic i_rst,
   qar_if.host pins,
   input wire logic i_req,
   input wire logic i_wr,
   input wire logic [1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_mode_b,
   input wire logic i_parity_en,
   input wire logic i_speed_hi,
   input wire logic i_inhibit,
   input wire logic [3:0] i_rx_one,
   input wire logic [3:0] i_rx_zero,
   output logic [7:0] o_rdata,
   output logic o_done,
   output logic o_irq,
   output logic [1:0] o_chan
);
   qar_pkg::qar_host_t q;
   qar_pkg::qar_host_t d;

   assign pins.phi2_clk = q.phi2;
   assign pins.reset_n = q.rst_n;
   assign pins.cs_n = q.cs_n;
   assign pins.dir_or_scan_inhibit = q.dir;
   assign pins.func_addr_lo = q.fa[0];
   assign pins.func_addr_hi = q.fa[1];
   assign pins.mode_b = q.mode_b;
   assign pins.parity_en = q.par_en;
   assign pins.data_h = q.wdata;
   assign pins.data_h_oe = q.doe;
   assign pins.speed_h = q.spd;
   assign pins.speed_h_oe = q.mode_b;
   assign {pins.rx3_one_pulse, pins.rx2_one_pulse} = q.one[3:2];
   assign {pins.rx1_one_pulse, pins.rx0_one_pulse} = q.one[1:0];
   assign {pins.rx3_zero_pulse, pins.rx2_zero_pulse} = q.zero[3:2];
   assign {pins.rx1_zero_pulse, pins.rx0_zero_pulse} = q.zero[1:0];
   assign o_rdata = q.rdata;
   assign o_done = q.done;
   assign o_irq = ~q.misc2[0];
   assign o_chan = q.misc2[2:1];

   // -------------------------------------------------
   // Next state
   // -------------------------------------------------
   always_comb begin
      d = q;
      d.rst_n = 1'b1;
      d.done = 1'b0;
      d.div = q.div + 4'h1;
      if (q.div == `QAR_HOST_DIV) begin
         d.div = 4'h0;
         d.phi2 = ~q.phi2;
      end
      d.rd1 = pins.data_bus;
      d.rd2 = q.rd1;
      d.misc1 = {1'b0, pins.tx_one_line_or_chan_bit1,
                 pins.tx_zero_line_or_chan_bit0, pins.irq_or_speed_sel};
      d.misc2 = q.misc1;
      d.mode_b = i_mode_b;
      d.par_en = i_parity_en;
      d.spd = i_speed_hi;
      d.one = i_rx_one;
      d.zero = i_rx_zero;
      case (q.st)
         qar_pkg::H_IDLE: begin
            d.dir = i_mode_b ? i_inhibit : 1'b1;
            if (i_req && i_mode_b && i_wr) begin
               d.done = 1'b1;
            end else if (i_req) begin
               // Select follows one cycle later, after address and data
               d.fa = i_addr;
               d.dir = i_mode_b ? i_inhibit : ~i_wr;
               d.wdata = i_wdata;
               d.doe = ~i_mode_b & i_wr;
               d.cnt = 8'h00;
               d.st = qar_pkg::H_ACCESS;
            end
         end
         qar_pkg::H_ACCESS: begin
            d.cnt = q.cnt + 8'h01;
            if (q.cnt == 8'h00) begin
               d.cs_n = 1'b0;
            end
            if (q.cnt == `QAR_HOST_HOLD) begin
               d.rdata = q.rd2;
               d.cs_n = 1'b1;
               d.doe = 1'b0;
               d.cnt = 8'h00;
               d.st = qar_pkg::H_RECOV;
            end
         end
         qar_pkg::H_RECOV: begin
            d.cnt = q.cnt + 8'h01;
            if (q.cnt == `QAR_HOST_RECOV) begin
               d.done = 1'b1;
               d.st = qar_pkg::H_IDLE;
            end
         end
         default: d.st = qar_pkg::H_IDLE;
      endcase
   end

   // -------------------------------------------------
   // State register
   // -------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         q <= '0;
         q.cs_n <= 1'b1;
         q.misc1 <= 4'h1;
         q.misc2 <= 4'h1;
      end else begin
         q <= d;
      end
   end
endmodule
`default_nettype wire

/* verification/qar_link_properties.sv */
// Pin level checks for the quad receiver link
`timescale 1ns/1ps
`default_nettype none
module qar_link_properties (
   input wire logic phi2_clk,
   input wire logic reset_n,
   input wire logic cs_n,
   input wire logic dir_or_scan_inhibit,
   input wire logic mode_b,
   input wire logic data_d_oe,
   input wire logic irq_d_oe,
   input wire logic speed_h_oe,
   input wire logic tx_zero_line_or_chan_bit0,
   input wire logic tx_one_line_or_chan_bit1
);
   // ---------------------------------
   // Scan sequences
   // ---------------------------------
   default clocking cb @(posedge phi2_clk);
   endclocking
   default disable iff (!reset_n);
   logic [1:0] chan;
   assign chan = {tx_one_line_or_chan_bit1, tx_zero_line_or_chan_bit0};
   sequence scan_free;
      (mode_b && !dir_or_scan_inhibit) [*8];
   endsequence
   sequence scan_held;
      (mode_b && dir_or_scan_inhibit) [*4];
   endsequence
   // ---------------------------------
   // Assertions
   // ---------------------------------
   a_read_needs_dir: assert property (data_d_oe && !mode_b |->
      dir_or_scan_inhibit) else $error("bus driven during write");
   a_select_gates_bus: assert property (data_d_oe |-> !cs_n ||
      !$past(cs_n) || !$past(cs_n, 2) || !$past(cs_n, 3))
      else $error("bus driven while not selected");
   a_irq_mode_a: assert property (mode_b && $past(mode_b, 3) |->
      !irq_d_oe) else $error("interrupt pulled in scan mode");
   a_tx_lines_excl: assert property (!mode_b && !$past(mode_b, 3) |->
      !(chan == 2'h3)) else $error("both transmit lines high");
   a_scan_steps: assert property (scan_free |->
      chan == $past(chan) + 2'h1) else $error("scan counter did not step");
   a_scan_inhibit: assert property (scan_held |-> $stable(chan))
      else $error("scan counter moved while inhibited");
   a_irq_pin_free: assert property (!mode_b |-> !speed_h_oe)
      else $error("host drives interrupt pin in processor mode");
   a_speed_pin_own: assert property (mode_b |-> speed_h_oe)
      else $error("host does not drive speed pin in scan mode");
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Self checking bench for the quad receiver link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic dev_rst = 1'b1;
   logic req = 1'b0, wr = 1'b0, mode_b = 1'b0, par_en = 1'b1, inh = 1'b0;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic [3:0] rx_one = 4'h0, rx_zero = 4'h0;
   logic [7:0] rdata;
   logic done, irq;
   logic [1:0] chan;
   logic [3:0] status;
   logic [31:0] rec_w = 32'h0;
   logic rec_p = 1'b0;
   int rec_n = 0;
   int miscompares = 0;
   int checked = 0;
   always #10 i_clk = ~i_clk;
   qar_if bus ();
   qar_host qar_host_i (.i_clk(i_clk), .i_rst(i_rst), .pins(bus.host),
      .i_req(req), .i_wr(wr), .i_addr(addr), .i_wdata(wdata),
      .i_mode_b(mode_b), .i_parity_en(par_en), .i_speed_hi(1'b0),
      .i_inhibit(inh), .i_rx_one(rx_one), .i_rx_zero(rx_zero),
      .o_rdata(rdata), .o_done(done), .o_irq(irq), .o_chan(chan));
   qar_dev qar_dev_i (.i_phi2_clk(bus.phi2_clk), .i_rst(dev_rst),
      .pins(bus.dev), .o_status(status));
   qar_link_properties qar_link_properties_i (.phi2_clk(bus.phi2_clk),
      .reset_n(bus.reset_n), .cs_n(bus.cs_n),
      .dir_or_scan_inhibit(bus.dir_or_scan_inhibit), .mode_b(bus.mode_b),
      .data_d_oe(bus.data_d_oe), .irq_d_oe(bus.irq_d_oe),
      .speed_h_oe(bus.speed_h_oe),
      .tx_zero_line_or_chan_bit0(bus.tx_zero_line_or_chan_bit0),
      .tx_one_line_or_chan_bit1(bus.tx_one_line_or_chan_bit1));
   // ---------------------------------
   // Shared tasks
   // ---------------------------------
   task automatic wrap_up;
      if (miscompares == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic access(input logic w, input logic [1:0] a,
      input logic [7:0] d, output int lat);
      lat = 0;
      @(negedge i_clk);
      req = 1'b1;
      wr = w;
      addr = a;
      wdata = d;
      @(negedge i_clk);
      req = 1'b0;
      while (done !== 1'b1 && lat < 300) begin
         @(negedge i_clk);
         lat++;
      end
   endtask
   task automatic wt(input logic [1:0] a, input logic [7:0] d);
      int lat;
      access(1'b1, a, d, lat);
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      int lat;
      access(1'b0, a, 8'h00, lat);
      cmp({24'h0, rdata}, {24'h0, e});
   endtask
   task automatic send(input logic [31:0] w, input logic [3:0] m);
      repeat (1000) @(negedge i_clk);
      for (int i = 0; i < 32; i++) begin
         rx_one = w[i] ? m : 4'h0;
         rx_zero = w[i] ? 4'h0 : m;
         repeat (32) @(negedge i_clk);
         rx_one = 4'h0;
         rx_zero = 4'h0;
         repeat (32) @(negedge i_clk);
      end
      repeat (1000) @(negedge i_clk);
   endtask
   task automatic restart(input logic b, input logic p);
      @(negedge i_clk);
      i_rst = 1'b1;
      dev_rst = 1'b1;
      mode_b = b;
      par_en = p;
      repeat (6) @(negedge i_clk);
      i_rst = 1'b0;
      repeat (16) @(negedge i_clk);
      dev_rst = 1'b0;
      repeat (200) @(negedge i_clk);
   endtask
   always @(posedge bus.phi2_clk) begin
      if (!rec_p && (bus.tx_zero_line_or_chan_bit0 ||
         bus.tx_one_line_or_chan_bit1)) begin
         rec_w = {bus.tx_one_line_or_chan_bit1, rec_w[31:1]};
         rec_n++;
      end
      rec_p = bus.tx_zero_line_or_chan_bit0 || bus.tx_one_line_or_chan_bit1;
   end
   // ---------------------------------
   // Scenarios
   // ---------------------------------
   task automatic test_rx_a;
      wt(2'h3, 8'h01);
      wt(2'h2, 8'ha5);
      send(32'h1234565a, 4'h1);
      send(32'h123457a5, 4'h1);
      rd(2'h3, 8'h00);
      cmp({31'h0, irq}, 32'h0);
      send(32'h123456a5, 4'h1);
      cmp({31'h0, irq}, 32'h1);
      cmp({28'h0, status}, 32'h1);
      rd(2'h3, 8'h01);
      rd(2'h0, 8'h56);
      rd(2'h1, 8'h34);
      rd(2'h2, 8'h12);
      rd(2'h3, 8'h00);
      cmp({31'h0, irq}, 32'h0);
      cmp({28'h0, status}, 32'h0);
   endtask
   task automatic test_tx_a;
      wt(2'h3, 8'h11);
      wt(2'h0, 8'hf1);
      wt(2'h0, 8'h00);
      wt(2'h0, 8'h00);
      wt(2'h0, 8'h80);
      wt(2'h1, 8'h05);
      rec_n = 0;
      wt(2'h3, 8'h21);
      rd(2'h3, 8'h80);
      repeat (3000) @(negedge i_clk);
      cmp(rec_n, 32'd32);
      cmp(rec_w, 32'h800000f1);
      rd(2'h3, 8'h10);
      cmp({31'h0, irq}, 32'h1);
      wt(2'h3, 8'h11);
      rd(2'h3, 8'h00);
      cmp({31'h0, irq}, 32'h0);
   endtask
   task automatic test_scan_b;
      int lat;
      logic [1:0] c;
      restart(1'b1, 1'b0);
      access(1'b1, 2'h3, 8'hff, lat);
      cmp(lat, 32'd0);
      send(32'h123457a5, 4'hf);
      @(negedge i_clk);
      inh = 1'b1;
      repeat (40) @(negedge i_clk);
      c = chan;
      rd(2'h3, 8'ha5);
      rd(2'h0, 8'h57);
      rd(2'h1, 8'h34);
      rd(2'h2, 8'h12);
      cmp({30'h0, chan}, {30'h0, c});
      inh = 1'b0;
      repeat (200) @(negedge i_clk);
   endtask
   // ---------------------------------
   // Main sequence and watchdog
   // ---------------------------------
   initial begin
      restart(1'b0, 1'b1);
      test_rx_a;
      test_tx_a;
      test_scan_b;
      wrap_up;
   end
   initial begin
      repeat (60000) @(posedge i_clk);
      miscompares++;
      wrap_up;
   end
endmodule
`default_nettype wire
